// ### rtl/etu_pkg.sv
// Package of constants and types for the exception and timer unit
package etu_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_SAVE_RESTORE_ZERO = 8'h00;
    localparam logic [7:0] OFF_SAVE_RESTORE_ONE = 8'h04;
    localparam logic [7:0] OFF_CRITICAL_SAVE_ADDR = 8'h08;
    localparam logic [7:0] OFF_CRITICAL_SAVE_STATE = 8'h0C;
    localparam logic [7:0] OFF_MACHINE_STATE = 8'h10;
    localparam logic [7:0] OFF_TIMER_STATUS = 8'h14;
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h18;
    localparam logic [7:0] OFF_PIT = 8'h1C;
    localparam logic [7:0] OFF_TB_LO = 8'h20;
    localparam logic [7:0] OFF_TB_HI = 8'h24;
    localparam logic [7:0] OFF_EXT_MASK = 8'h28;

    // ==========================================================
    // Field positions
    localparam int TCR_PIT_IE = 0;
    localparam int TCR_PIT_AUTO = 1;
    localparam int TCR_FIT_SEL = 2;
    localparam int TCR_FIT_IE = 4;
    localparam int TCR_WDT_SEL = 5;
    localparam int TCR_WDT_RST = 7;
    localparam int TCR_WDT_IE = 9;
    localparam int TCR_TB_EXT = 10;
    localparam int TSR_PIT = 0;
    localparam int TSR_FIT = 1;
    localparam int TSR_WDT_STAGE = 2;
    localparam int TSR_WDT_INT = 3;
    localparam int MSR_EE = 15;
    localparam int MSR_CE = 17;
    localparam int EXT_CRIT_MASK = 5;

    // Time base taps for the fixed interval and watchdog periods
    localparam int FIT_TAP [4] = '{9, 13, 17, 21};
    localparam int WDT_TAP [4] = '{17, 21, 25, 29};

    // ==========================================================
    // Reset values and vectors
    localparam logic [31:0] MSR_RST = 32'h0000_0000;
    localparam logic [31:0] TCR_RST = 32'h0000_0000;
    localparam logic [31:0] EXT_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] VEC_BASE = 32'h0000_0000;
    localparam int VEC_SHIFT = 8;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        EXC_NONE, EXC_RESET, EXC_MCHECK, EXC_DEBUG, EXC_CRIT, EXC_WDOG,
        EXC_PROG, EXC_ALIGN, EXC_EXT, EXC_FIT, EXC_PIT
    } etu_cause_t;

    typedef struct packed {
        logic [31:0] fault_pc;
        logic [31:0] next_pc;
        logic drained;
        logic multicycle;
        logic syscall;
    } etu_pipe_t;

    typedef struct packed {
        logic mcheck;
        logic debug;
        logic prog;
        logic align;
    } etu_sync_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] pc;
        etu_cause_t cause;
        logic critical;
    } etu_redirect_t;

endpackage

// ### rtl/etu_top.sv
// Exception prioritisation, context save/restore and timer facility
// ==========================================================
// Operation
// - One exception serviced at a time
// - Pending exceptions taken by fixed priority
// - Reset and machine check imprecise, others precise
// - Wait drain; faulting or next address saved
// - Critical: check, debug, pin, first watchdog
// - Noncritical saves address, state; updates state
// - Multicycle operation aborted, own address saved
// - Normal return restores address and state
// - Critical uses third, fourth save registers
// - Six maskable external inputs, one critical
// - 64-bit time base, selectable timer clock
// - Time base wrap raises nothing
// - 32-bit preloaded interval counter decrements
// - At zero: stop, flag, request interrupt
// - Auto-reload restarts from last written value
// - Interval timer interrupt enable in control
// - Four fixed periods, enable in control
// - Rising selected bit sets fixed flag
// - Watchdog: four periods, reset after two
`timescale 1ns/1ps
module etu_top
    import etu_pkg::*;
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pipeline side
    input wire etu_pipe_t pipe,
    input wire etu_sync_req_t sync_req,
    input wire logic sys_reset_req,
    input wire logic ret_normal,
    input wire logic ret_critical,
    output etu_redirect_t redirect,
    output logic abort_multicycle,
    output logic [31:0] machine_state,
    // Pins
    input wire logic critical_interrupt_pin_n,
    input wire logic [4:0] ext_irq_pin,
    input wire logic timer_clk_pin,
    // Watchdog reset request
    output logic wdt_reset,
    output logic [1:0] wdt_reset_type
);

    // ==========================================================
    // Helpers
    function automatic logic is_crit(input etu_cause_t c);
        return (c == EXC_MCHECK) || (c == EXC_DEBUG) || (c == EXC_CRIT) || (c == EXC_WDOG);
    endfunction
    function automatic logic reg_known(input logic [7:0] a);
        return (a <= OFF_EXT_MASK) && (a[1:0] == 2'h0);
    endfunction
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic [6:0] pin_meta_ff;
    logic [6:0] pin_sync_ff;
    logic tclk_prev_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_ff <= 7'h40;
            pin_sync_ff <= 7'h40;
            tclk_prev_ff <= 1'b0;
        end else if (ce) begin
            pin_meta_ff <= {critical_interrupt_pin_n, timer_clk_pin, ext_irq_pin};
            pin_sync_ff <= pin_meta_ff;
            tclk_prev_ff <= pin_sync_ff[5];
        end
    end
    wire [4:0] ext_sync = pin_sync_ff[4:0];
    wire tclk_sync = pin_sync_ff[5];
    wire crit_pin_n_sync = pin_sync_ff[6];

    // ==========================================================
    // AXI4-Lite slave
    logic [31:0] save_restore_zero_ff, save_restore_one_ff, critical_save_addr_ff, critical_save_state_ff, msr_ff;
    logic [31:0] tsr_ff, tcr_ff, pit_ff, pit_reload_ff, ext_mask_ff;
    logic [63:0] tb_ff;
    logic aw_v_ff, w_v_ff, bvalid_ff, rvalid_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff, rdata_ff;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rd_mux;

    assign s_axi_awready = !aw_v_ff && !bvalid_ff;
    assign s_axi_wready = !w_v_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire wr_go = aw_v_ff && w_v_ff && !bvalid_ff;
    wire [31:0] wmask = strb_mask(w_strb_ff);
    wire [31:0] wbits = w_data_ff & wmask;
    wire wr_save_restore_zero = wr_go && (aw_addr_ff == OFF_SAVE_RESTORE_ZERO);
    wire wr_save_restore_one = wr_go && (aw_addr_ff == OFF_SAVE_RESTORE_ONE);
    wire wr_critical_save_addr = wr_go && (aw_addr_ff == OFF_CRITICAL_SAVE_ADDR);
    wire wr_critical_save_state = wr_go && (aw_addr_ff == OFF_CRITICAL_SAVE_STATE);
    wire wr_msr = wr_go && (aw_addr_ff == OFF_MACHINE_STATE);
    wire wr_tsr = wr_go && (aw_addr_ff == OFF_TIMER_STATUS);
    wire wr_tcr = wr_go && (aw_addr_ff == OFF_TIMER_CONTROL);
    wire wr_pit = wr_go && (aw_addr_ff == OFF_PIT);
    wire wr_mask = wr_go && (aw_addr_ff == OFF_EXT_MASK);

    always_comb begin
        unique case (s_axi_araddr)
            OFF_SAVE_RESTORE_ZERO: rd_mux = save_restore_zero_ff;
            OFF_SAVE_RESTORE_ONE: rd_mux = save_restore_one_ff;
            OFF_CRITICAL_SAVE_ADDR: rd_mux = critical_save_addr_ff;
            OFF_CRITICAL_SAVE_STATE: rd_mux = critical_save_state_ff;
            OFF_MACHINE_STATE: rd_mux = msr_ff;
            OFF_TIMER_STATUS: rd_mux = tsr_ff;
            OFF_TIMER_CONTROL: rd_mux = tcr_ff;
            OFF_PIT: rd_mux = pit_ff;
            OFF_TB_LO: rd_mux = tb_ff[31:0];
            OFF_TB_HI: rd_mux = tb_ff[63:32];
            OFF_EXT_MASK: rd_mux = ext_mask_ff;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_ff <= 1'b0;
            w_v_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bresp_ff <= 2'h0;
            rresp_ff <= 2'h0;
            rdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            if (aw_hs) begin
                aw_v_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_v_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_v_ff <= 1'b0;
                w_v_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= reg_known(aw_addr_ff) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (ar_hs) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= reg_known(s_axi_araddr) ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ==========================================================
    // Timers
    wire tb_tick = tcr_ff[TCR_TB_EXT] ? (tclk_sync && !tclk_prev_ff) : 1'b1;
    wire [63:0] nxt_tb = tb_tick ? tb_ff + 64'h1 : tb_ff; // Wrap is silent
    wire [1:0] fit_sel = tcr_ff[TCR_FIT_SEL +: 2];
    wire [1:0] wdt_sel = tcr_ff[TCR_WDT_SEL +: 2];
    wire [1:0] wdt_type = tcr_ff[TCR_WDT_RST +: 2];
    wire fit_bit = tb_ff[FIT_TAP[fit_sel]];
    wire wdt_bit = tb_ff[WDT_TAP[wdt_sel]];
    logic fit_prev_ff, wdt_prev_ff, wdt_reset_ff;
    logic [1:0] wdt_type_ff;
    wire fit_rise = fit_bit && !fit_prev_ff;
    wire wdt_rise = wdt_bit && !wdt_prev_ff;
    wire wdt_first = wdt_rise && !tsr_ff[TSR_WDT_STAGE];
    wire wdt_second = wdt_rise && tsr_ff[TSR_WDT_STAGE] && (wdt_type != 2'h0);

    // Decrement stalls at zero; reload only when auto mode is on
    wire pit_hit = tb_tick && (pit_ff == 32'h0000_0001);
    wire [31:0] pit_dec = (tb_tick && pit_ff != 32'h0000_0000) ? pit_ff - 32'h1 : pit_ff;
    wire [31:0] pit_wr = (pit_reload_ff & ~wmask) | wbits;
    wire [31:0] nxt_pit = wr_pit ? pit_wr :
        (pit_hit && tcr_ff[TCR_PIT_AUTO]) ? pit_reload_ff : pit_dec;

    // Hardware set wins over software clear
    wire [31:0] tsr_set = (32'(pit_hit) << TSR_PIT) | (32'(fit_rise) << TSR_FIT) |
        (32'(wdt_first) << TSR_WDT_STAGE) | (32'(wdt_first) << TSR_WDT_INT);
    wire [31:0] nxt_tsr = (tsr_ff & ~(wr_tsr ? wbits : 32'h0)) | tsr_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tb_ff <= 64'h0;
            pit_ff <= 32'h0000_0000;
            pit_reload_ff <= 32'h0000_0000;
            tsr_ff <= 32'h0000_0000;
            tcr_ff <= TCR_RST;
            ext_mask_ff <= EXT_MASK_RST;
            fit_prev_ff <= 1'b0;
            wdt_prev_ff <= 1'b0;
            wdt_reset_ff <= 1'b0;
            wdt_type_ff <= 2'h0;
        end else if (ce) begin
            tb_ff <= nxt_tb;
            pit_ff <= nxt_pit;
            tsr_ff <= nxt_tsr;
            fit_prev_ff <= fit_bit;
            wdt_prev_ff <= wdt_bit;
            wdt_reset_ff <= wdt_second;
            wdt_type_ff <= wdt_second ? wdt_type : wdt_type_ff;
            pit_reload_ff <= wr_pit ? pit_wr : pit_reload_ff;
            tcr_ff <= wr_tcr ? ((tcr_ff & ~wmask) | wbits) : tcr_ff;
            ext_mask_ff <= wr_mask ? ((ext_mask_ff & ~wmask) | wbits) : ext_mask_ff;
        end
    end
    assign wdt_reset = wdt_reset_ff;
    assign wdt_reset_type = wdt_type_ff;

    // ==========================================================
    // Pending sources
    logic crit_pend_ff, reset_pend_ff;
    // Held causes are stale while redirect stands; the pipeline is flushing
    wire etu_sync_req_t sync_live = redirect.valid ? etu_sync_req_t'(4'h0) : sync_req;
    wire ee = msr_ff[MSR_EE];
    wire cen = msr_ff[MSR_CE];
    wire ext_pend = |(ext_sync & ext_mask_ff[4:0]) && ee;
    wire crit_ok = crit_pend_ff && ext_mask_ff[EXT_CRIT_MASK] && cen;
    wire wdog_pend = tsr_ff[TSR_WDT_INT] && tcr_ff[TCR_WDT_IE] && cen;
    wire fit_pend = tsr_ff[TSR_FIT] && tcr_ff[TCR_FIT_IE] && ee;
    wire pit_pend = tsr_ff[TSR_PIT] && tcr_ff[TCR_PIT_IE] && ee;

    // Fixed priority; system reset first, interval timer last
    wire etu_cause_t pick =
        reset_pend_ff ? EXC_RESET :
        sync_live.mcheck ? EXC_MCHECK :
        sync_live.debug ? EXC_DEBUG :
        crit_ok ? EXC_CRIT :
        wdog_pend ? EXC_WDOG :
        sync_live.prog ? EXC_PROG :
        sync_live.align ? EXC_ALIGN :
        ext_pend ? EXC_EXT :
        fit_pend ? EXC_FIT :
        pit_pend ? EXC_PIT : EXC_NONE;

    // ==========================================================
    // Exception sequencer
    typedef enum logic {ST_IDLE, ST_DRAIN} etu_state_t;
    etu_state_t state_ff;
    etu_cause_t cause_ff;
    logic was_multi_ff, syscall_ff;
    etu_redirect_t redir_ff;

    wire imprecise = (pick == EXC_RESET) || (pick == EXC_MCHECK);
    wire in_idle = (state_ff == ST_IDLE);
    wire start_precise = in_idle && (pick != EXC_NONE) && !imprecise;
    // Precise causes wait for all earlier instructions to retire
    wire take_fire = (in_idle && imprecise) || (!in_idle && pipe.drained);
    wire etu_cause_t take_cause = in_idle ? pick : cause_ff;
    wire take_crit = is_crit(take_cause);
    wire take_reset = (take_cause == EXC_RESET);
    wire sync_cause = (take_cause == EXC_DEBUG) || (take_cause == EXC_ALIGN) ||
        ((take_cause == EXC_PROG) && !syscall_ff);
    wire [31:0] ret_addr = (sync_cause || was_multi_ff) ? pipe.fault_pc : pipe.next_pc;
    assign abort_multicycle = !in_idle && was_multi_ff;

    wire [31:0] vec_pc = VEC_BASE | (32'(take_cause) << VEC_SHIFT);
    wire [31:0] msr_clr = take_crit ? ((32'h1 << MSR_EE) | (32'h1 << MSR_CE)) : (32'h1 << MSR_EE);
    wire do_rfi = ret_normal && !take_fire;
    wire do_rfci = ret_critical && !take_fire && !ret_normal;
    wire [31:0] nxt_msr = take_fire ? (take_reset ? MSR_RST : msr_ff & ~msr_clr) :
        do_rfi ? save_restore_one_ff :
        do_rfci ? critical_save_state_ff :
        wr_msr ? ((msr_ff & ~wmask) | wbits) : msr_ff;
    wire save_nc = take_fire && !take_crit && !take_reset;
    wire save_cr = take_fire && take_crit;
    wire [31:0] nxt_save_restore_zero = save_nc ? ret_addr : wr_save_restore_zero ? (save_restore_zero_ff & ~wmask) | wbits : save_restore_zero_ff;
    wire [31:0] nxt_save_restore_one = save_nc ? msr_ff : wr_save_restore_one ? (save_restore_one_ff & ~wmask) | wbits : save_restore_one_ff;
    wire [31:0] nxt_critical_save_addr = save_cr ? ret_addr : wr_critical_save_addr ? (critical_save_addr_ff & ~wmask) | wbits : critical_save_addr_ff;
    wire [31:0] nxt_critical_save_state = save_cr ? msr_ff : wr_critical_save_state ? (critical_save_state_ff & ~wmask) | wbits : critical_save_state_ff;
    wire etu_redirect_t nxt_redir = take_fire ? etu_redirect_t'{1'b1, vec_pc, take_cause, take_crit} :
        do_rfi ? etu_redirect_t'{1'b1, save_restore_zero_ff, EXC_NONE, 1'b0} :
        do_rfci ? etu_redirect_t'{1'b1, critical_save_addr_ff, EXC_NONE, 1'b1} : etu_redirect_t'{1'b0, 32'h0, EXC_NONE, 1'b0};
    // Pin pending sticks until taken; a new low on the take cycle wins
    wire nxt_crit_pend = !crit_pin_n_sync || (crit_pend_ff && !(take_fire && take_cause == EXC_CRIT));
    wire nxt_reset_pend = sys_reset_req || wdt_second || (reset_pend_ff && !(take_fire && take_reset));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            cause_ff <= EXC_NONE;
            was_multi_ff <= 1'b0;
            syscall_ff <= 1'b0;
            redir_ff <= '{1'b0, 32'h0, EXC_NONE, 1'b0};
            crit_pend_ff <= 1'b0;
            reset_pend_ff <= 1'b0;
            msr_ff <= MSR_RST;
            save_restore_zero_ff <= 32'h0000_0000;
            save_restore_one_ff <= 32'h0000_0000;
            critical_save_addr_ff <= 32'h0000_0000;
            critical_save_state_ff <= 32'h0000_0000;
        end else if (ce) begin
            if (start_precise) begin
                state_ff <= ST_DRAIN;
                cause_ff <= pick;
                was_multi_ff <= pipe.multicycle;
                syscall_ff <= pipe.syscall;
            end else if (take_fire) begin
                state_ff <= ST_IDLE;
                was_multi_ff <= 1'b0;
            end
            redir_ff <= nxt_redir;
            crit_pend_ff <= nxt_crit_pend;
            reset_pend_ff <= nxt_reset_pend;
            msr_ff <= nxt_msr;
            save_restore_zero_ff <= nxt_save_restore_zero;
            save_restore_one_ff <= nxt_save_restore_one;
            critical_save_addr_ff <= nxt_critical_save_addr;
            critical_save_state_ff <= nxt_critical_save_state;
        end
    end
    assign redirect = redir_ff;
    assign machine_state = msr_ff;

    // ==========================================================
    // Assertions
    a_one_exception: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !in_idle && !pipe.drained |=> state_ff == ST_DRAIN && cause_ff == $past(cause_ff))
        else $error("second exception started before first taken");
    a_pit_lowest: assert property (@(posedge aclk) disable iff (!aresetn)
        pick == EXC_PIT |-> !fit_pend && !ext_pend && !crit_ok && !wdog_pend && !sync_live.prog)
        else $error("interval timer chosen over higher source");
    a_imprecise_now: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && in_idle && sync_live.mcheck && !reset_pend_ff |=> redirect.valid && redirect.cause == EXC_MCHECK)
        else $error("machine check not taken at once");
    a_precise_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        !in_idle && !pipe.drained |-> !take_fire)
        else $error("precise exception taken before drain");
    a_nc_save: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && save_nc |=> save_restore_zero_ff == $past(ret_addr) && save_restore_one_ff == $past(msr_ff) && !msr_ff[MSR_EE])
        else $error("noncritical context not saved");
    a_crit_save: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && save_cr |=> critical_save_addr_ff == $past(ret_addr) && critical_save_state_ff == $past(msr_ff) && save_restore_zero_ff == $past(save_restore_zero_ff))
        else $error("critical context not saved");
    a_rfi_restore: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && do_rfi |=> msr_ff == $past(save_restore_one_ff) && redirect.pc == $past(save_restore_zero_ff))
        else $error("normal return did not restore");
    a_pit_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && pit_ff == 32'h0000_0001 && tb_tick && !wr_pit |=> tsr_ff[TSR_PIT] && (pit_ff == 32'h0 || tcr_ff[TCR_PIT_AUTO]))
        else $error("interval counter zero not flagged");
    a_pit_stall: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && pit_ff == 32'h0 && !wr_pit |=> pit_ff == 32'h0)
        else $error("interval counter moved past zero");
    a_tb_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && tb_tick && tb_ff == 64'hFFFF_FFFF_FFFF_FFFF |=> tb_ff == 64'h0)
        else $error("time base wrap wrong");
    a_fit_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && fit_rise |=> tsr_ff[TSR_FIT])
        else $error("fixed interval edge not flagged");
    a_wdt_second: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wdt_second |=> wdt_reset && wdt_reset_type == $past(wdt_type))
        else $error("watchdog second expiry gave no reset");
    c_crit_taken: cover property (@(posedge aclk) redirect.valid && redirect.cause == EXC_CRIT);
    c_pit_reload: cover property (@(posedge aclk) pit_hit && tcr_ff[TCR_PIT_AUTO]);
    c_drain_multi: cover property (@(posedge aclk) take_fire && was_multi_ff);
    c_wdt_reset: cover property (@(posedge aclk) wdt_reset);

endmodule

// ### tb/etu_pipe_model.sv
// Pipeline model: holds sync causes and drains every other cycle
`timescale 1ns/1ps
module etu_pipe_model
    import etu_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench request and unit redirect
    input wire etu_sync_req_t req,
    input wire etu_redirect_t redirect,
    input wire logic multi,
    // Toward the unit
    output etu_pipe_t pipe,
    output etu_sync_req_t sync_req
);
    logic [3:0] pend_ff;
    logic drained_ff;
    wire logic [3:0] shown = !redirect.valid ? 4'h0 : redirect.cause == EXC_ALIGN ? 4'h1 :
        redirect.cause == EXC_PROG ? 4'h2 : redirect.cause == EXC_DEBUG ? 4'h4 :
        redirect.cause == EXC_MCHECK ? 4'h8 : 4'h0;
    always_ff @(posedge aclk) begin
        pend_ff <= aresetn ? (pend_ff | req) & ~shown : 4'h0;
        drained_ff <= aresetn & ~drained_ff; // Slow drain
    end
    assign sync_req = pend_ff;
    assign pipe = {32'h0000_1000, 32'h0000_1004, drained_ff, multi, 1'b0};
endmodule

// ### tb/exception_and_timer_unit_test.sv
// Self-checking bench for the exception and timer unit
`timescale 1ns/1ps
module exception_and_timer_unit_test
    import etu_pkg::*;
;
    logic aclk = 0, aresetn = 0, ce = 1, sys_reset_req = 0, ret_normal = 0, ret_critical = 0;
    logic critical_interrupt_pin_n = 1, timer_clk_pin = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1, multi = 0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [4:0] ext_irq_pin = 5'h00;
    etu_sync_req_t req = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, abort_multicycle, wdt_reset;
    logic [1:0] s_axi_bresp, s_axi_rresp, wdt_reset_type, rr;
    logic [31:0] s_axi_rdata, machine_state, rv, last_pc, t0;
    etu_pipe_t pipe;
    etu_sync_req_t sync_req;
    etu_redirect_t redirect;
    logic [3:0] cq[$];
    int failures = 0, comparisons = 0, aborts = 0;
    etu_top DUT (.*);
    etu_pipe_model PM (.aclk, .aresetn, .req, .redirect, .multi, .pipe, .sync_req);
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) if (redirect.valid === 1'b1) begin
        cq.push_back(redirect.cause);
        last_pc = redirect.pc;
    end
    always @(posedge aclk) if (abort_multicycle === 1'b1) aborts++;
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, e, rv & m);
    endtask
    task automatic fire(input logic [3:0] r);
        req <= r;
        @(posedge aclk);
        req <= 4'h0;
        repeat (20) @(posedge aclk);
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rc(OFF_MACHINE_STATE, '1, MSR_RST, "msr reset");
        rc(OFF_TIMER_CONTROL, '1, TCR_RST, "tcr reset");
        rd(8'h2C);
        chk("unmapped resp", 32'h2, 32'(rr));
        wr(8'h2C, 32'h0);
        chk("unmapped bresp", 32'h2, 32'(rr));
        wr(OFF_MACHINE_STATE, 32'h0002_8000);
        cq.delete();
        fire(4'h1);
        chk("cause", 32'(EXC_ALIGN), 32'(cq[0]));
        chk("vector", VEC_BASE | (32'(EXC_ALIGN) << VEC_SHIFT), last_pc);
        rc(OFF_SAVE_RESTORE_ZERO, '1, 32'h0000_1000, "save_restore_zero");
        rc(OFF_SAVE_RESTORE_ONE, '1, 32'h0002_8000, "save_restore_one");
        rc(OFF_MACHINE_STATE, '1, 32'h0002_0000, "msr taken");
        ret_normal <= 1;
        @(posedge aclk);
        ret_normal <= 0;
        repeat (4) @(posedge aclk);
        chk("ret pc", 32'h0000_1000, last_pc);
        chk("ret msr", 32'h0002_8000, machine_state);
        cq.delete();
        fire(4'h5);
        chk("first", 32'(EXC_DEBUG), 32'(cq[0]));
        chk("second", 32'(EXC_ALIGN), 32'(cq[1]));
        rc(OFF_CRITICAL_SAVE_ADDR, '1, 32'h0000_1000, "crit addr");
        rc(OFF_CRITICAL_SAVE_STATE, '1, 32'h0002_8000, "crit state");
        wr(OFF_EXT_MASK, 32'h1);
        wr(OFF_MACHINE_STATE, 32'h0000_8000);
        cq.delete();
        ext_irq_pin <= 5'h01;
        repeat (20) @(posedge aclk);
        ext_irq_pin <= 5'h00;
        chk("ext cause", 32'(EXC_EXT), 32'(cq[0]));
        rc(OFF_SAVE_RESTORE_ZERO, '1, 32'h0000_1004, "save_restore_zero next");
        wr(OFF_PIT, 32'h8);
        repeat (20) @(posedge aclk);
        rc(OFF_PIT, '1, 32'h0, "pit count");
        rc(OFF_TIMER_STATUS, 32'h1, 32'h1, "pit flag");
        wr(OFF_TIMER_STATUS, 32'h1);
        rc(OFF_TIMER_STATUS, 32'h1, 32'h0, "pit clear");
        wr(OFF_EXT_MASK, 32'h20);
        wr(OFF_MACHINE_STATE, 32'h0002_0000);
        cq.delete();
        multi <= 1;
        critical_interrupt_pin_n <= 0;
        @(posedge aclk);
        critical_interrupt_pin_n <= 1;
        repeat (20) @(posedge aclk);
        multi <= 0;
        chk("crit cause", 32'(EXC_CRIT), 32'(cq[0]));
        chk("abort seen", 32'h1, 32'(aborts > 0));
        rc(OFF_CRITICAL_SAVE_ADDR, '1, 32'h0000_1000, "crit multi addr");
        rc(OFF_CRITICAL_SAVE_STATE, '1, 32'h0002_0000, "crit pin state");
        rc(OFF_MACHINE_STATE, '1, 32'h0, "crit msr");
        cq.delete();
        fire(4'h8);
        chk("mcheck cause", 32'(EXC_MCHECK), 32'(cq[0]));
        chk("mcheck once", 32'h1, 32'(cq.size()));
        rd(OFF_TB_LO);
        t0 = rv;
        ce <= 0;
        repeat (10) @(posedge aclk);
        ce <= 1;
        rc(OFF_TB_LO, '1, t0 + 32'h2, "tb frozen");
        tally_and_finish;
    end
    initial begin
        repeat (3000) @(posedge aclk);
        failures++;
        tally_and_finish;
    end
endmodule
